// ### hw/cell_group.sv
// Logic cell group: cells, group controls, cascade and register slave.
//
// Operation
// - Cascade joins lookup outputs by AND or OR.
// - Each chained cell adds four more inputs.
// - Chains beyond ten cells continue into another group.
// - Groups link even to even, odd to odd.
// - Normal mode four-input lookup, carry replaces input c.
// - Normal lookup combines with incoming cascade.
// - Packed register, lost when carry feeds lookup.
// - Arithmetic mode: sum table and carry table.
// - Arithmetic allows cascade, registered and unregistered outputs.
// - Counter: enables, direction, clear and load.
// - Input a steers counter enable except in the second cell.
// - Clear and load act on whole group.
// - Two group clock enables, each cell picks one.
// - First cell feeds its register back.
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/10ps
`include "cell_group_consts.svh"
module cell_group #(
  parameter int CELLS     = `CELLS_DEFAULT,  // Cells in the group.
  parameter bit GROUP_ODD = 1'b0             // Parity of the group in its row.
) (
  input  wire logic             ref_clk,           // Cell clock.
  input  wire logic             rst,               // Synchronous reset, high.
  input  wire logic [7:0]       avs_address,       // Byte address.
  input  wire logic             avs_read,          // Read request.
  input  wire logic             avs_write,         // Write request.
  input  wire logic [31:0]      avs_writedata,     // Write data.
  input  wire logic [3:0]       avs_byteenable,    // Byte lanes of a write.
  output logic [31:0]           avs_readdata,      // Read data.
  output logic                  avs_waitrequest,   // Slave not ready.
  input  wire logic [CELLS-1:0] operand_in_a,      // Operand a of each cell.
  input  wire logic [CELLS-1:0] operand_in_b,      // Operand b of each cell.
  input  wire logic [CELLS-1:0] operand_in_c,      // Operand c of each cell.
  input  wire logic [CELLS-1:0] operand_in_d,      // Operand d, packed and load data.
  input  wire logic             carry_in,          // Carry into the first cell.
  output logic                  carry_out,         // Carry out of the last cell.
  input  wire logic             sync_clear,        // Group synchronous clear.
  input  wire logic             sync_load,         // Group synchronous load.
  input  wire logic             clk_en0,           // Group clock enable zero.
  input  wire logic             clk_en1,           // Group clock enable one.
  input  wire logic             cascade_in_even,   // Chain from previous even group.
  input  wire logic             cascade_in_odd,    // Chain from previous odd group.
  output logic                  cascade_out_even,  // Chain to next even group.
  output logic                  cascade_out_odd,   // Chain to next odd group.
  output logic [CELLS-1:0]      comb_out,          // Unregistered cell outputs.
  output logic [CELLS-1:0]      reg_out            // Registered cell outputs.
);
  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // The cell windows must fit an eight bit byte address.
  if (CELLS < 2 || CELLS > `CELLS_MAX) begin : g_bad_cells
    $error("cell_group: CELLS must lie between 2 and 16");
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [CELLS-1:0][15:0]         lut;    // Lookup masks.
    logic [CELLS-1:0][`CTRL_W-1:0] ctrl;   // Control words.
    logic [CELLS-1:0]               q;      // Cell registers.
    logic                           ack;    // Bus answer phase.
    logic [31:0]                    rdata;  // Read data holding register.
  } state_s;

  state_s           st_reg;                 // Registered state.
  state_s           st_next;                // Next state.
  logic [CELLS:0]   carry_w;                // Carry chain taps.
  logic [CELLS:0]   casc_w;                 // Cascade chain taps.
  logic [CELLS-1:0] cell_d;                 // Next value of each register.
  logic [CELLS-1:0] ce_w;                   // Selected clock enable per cell.
  logic [CELLS-1:0] c_eff;                  // Operand c after feedback.
  logic [7:0]       rel_addr;               // Address inside the cell windows.
  logic [4:0]       cell_idx;               // Cell addressed by the bus.
  logic             in_cells;               // Address hits a cell window.
  logic             bus_req;                // Read or write pending.

  // ************************************************************
  // Cascade between groups
  // ************************************************************
  cascade_link #(
    .GROUP_ODD (GROUP_ODD)
  ) u_link (
    .chain_last  (casc_w[CELLS]),
    .in_even     (cascade_in_even),
    .in_odd      (cascade_in_odd),
    .chain_first (casc_w[0]),
    .out_even    (cascade_out_even),
    .out_odd     (cascade_out_odd)
  );

  // The carry chain enters at cell zero and leaves past the last cell.
  assign carry_w[0] = carry_in;
  assign carry_out  = carry_w[CELLS];
  assign reg_out    = st_reg.q;

  // ************************************************************
  // Cells
  // ************************************************************
  for (genvar i = 0; i < CELLS; i++) begin : g_cell
    logic [`CTRL_W-1:0]         ctl;       // Control word of this cell.
    cell_group_pkg::cell_mode_e mode;      // Decoded mode.
    logic                       cnt_en;    // Counter enable in use.
    logic                       data_in;   // Value captured when no override acts.
    logic                       packed_ok; // Packed register may take operand d.

    assign ctl  = st_reg.ctrl[i];
    assign mode = cell_group_pkg::cell_mode_e'(ctl[`F_MODE_HI:`F_MODE_LO]);

    // Only the first cell owns the feedback multiplexer.
    if (i == 0) begin : g_fb
      assign c_eff[i] = ctl[`F_FEEDBACK] ? st_reg.q[i] : operand_in_c[i];
    end else begin : g_nofb
      assign c_eff[i] = operand_in_c[i];
    end

    cell_function u_fn (
      .lut_mask    (st_reg.lut[i]),
      .ctrl        (ctl),
      .in_a        (operand_in_a[i]),
      .in_b        (operand_in_b[i]),
      .in_c        (c_eff[i]),
      .in_d        (operand_in_d[i]),
      .carry_in    (carry_w[i]),
      .cascade_in  (casc_w[i]),
      .reg_q       (st_reg.q[i]),
      .comb_out    (comb_out[i]),
      .carry_out   (carry_w[i+1]),
      .cascade_out (casc_w[i+1])
    );

    // Each register follows one of the two group enables.
    assign ce_w[i] = ctl[`F_CE_SEL] ? clk_en1 : clk_en0;

    // The second cell has no data path for its counter controls, so it
    // always takes the stored enable whatever the source bit says.
    if (i == 1) begin : g_second
      assign cnt_en = ctl[`F_CNT_EN];
    end else begin : g_other
      assign cnt_en = ctl[`F_CTL_DATA] ? operand_in_a[i] : ctl[`F_CNT_EN];
      // A low operand a must freeze a counter bit that takes its enable from data.
      data_enable_a: assert property (@(posedge ref_clk) disable iff (rst)
        ce_w[i] && !sync_clear && !sync_load && mode == cell_group_pkg::mode_counter
        && ctl[`F_CTL_DATA] && !operand_in_a[i] |=> $stable(st_reg.q[i]))
        else $error("data counter enable ignored");
    end

    // Carry into the lookup steals the packed register's data path.
    assign packed_ok = (mode == cell_group_pkg::mode_normal) && ctl[`F_PACKED]
                       && !ctl[`F_CARRY_SEL];
    assign data_in   = packed_ok ? operand_in_d[i] : comb_out[i];

    // Clear beats load, and load beats counting or capture.
    // A counter bit toggles only when every lower bit lets the carry through.
    always_comb begin
      if (!ce_w[i]) begin
        cell_d[i] = st_reg.q[i];
      end else if (sync_clear) begin
        cell_d[i] = 1'b0;
      end else if (sync_load) begin
        cell_d[i] = operand_in_d[i];
      end else if (mode == cell_group_pkg::mode_counter) begin
        cell_d[i] = cnt_en ? (st_reg.q[i] ^ carry_w[i]) : st_reg.q[i];
      end else begin
        cell_d[i] = data_in;
      end
    end

    // ************************************************************
    // Cell checks
    // ************************************************************
    clear_wins_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce_w[i] && sync_clear |=> !st_reg.q[i])
      else $error("clear did not win over load or count");

    load_takes_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce_w[i] && !sync_clear && sync_load |=> st_reg.q[i] == $past(operand_in_d[i]))
      else $error("group load not taken");

    enable_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      !ce_w[i] |=> $stable(st_reg.q[i]))
      else $error("register moved without its clock enable");

    count_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce_w[i] && !sync_clear && !sync_load && mode == cell_group_pkg::mode_counter
      && !cnt_en |=> $stable(st_reg.q[i]))
      else $error("counter moved while disabled");

    count_step_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce_w[i] && !sync_clear && !sync_load && mode == cell_group_pkg::mode_counter
      && cnt_en && carry_w[i] |=> st_reg.q[i] != $past(st_reg.q[i]))
      else $error("counter bit did not toggle on carry");

    packed_lost_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce_w[i] && !sync_clear && !sync_load && mode == cell_group_pkg::mode_normal
      && ctl[`F_CARRY_SEL] |=> st_reg.q[i] == $past(comb_out[i]))
      else $error("packed register used while carry feeds lookup");

    arith_reg_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce_w[i] && !sync_clear && !sync_load && mode == cell_group_pkg::mode_arith
      |=> st_reg.q[i] == $past(comb_out[i]))
      else $error("registered copy differs from lookup output");

    adder_sum_a: assert property (@(posedge ref_clk) disable iff (rst)
      mode == cell_group_pkg::mode_arith && st_reg.lut[i] == 16'hE896
      |-> {carry_w[i+1], comb_out[i]} == 2'(operand_in_a[i] + operand_in_b[i]
                                              + carry_w[i]))
      else $error("full adder tables give a wrong sum");

    casc_and_a: assert property (@(posedge ref_clk) disable iff (rst)
      mode != cell_group_pkg::mode_counter && ctl[`F_CASC_EN] && !ctl[`F_CASC_OR]
      && !casc_w[i] |-> !casc_w[i+1])
      else $error("AND cascade passed a one past a zero");

    casc_or_a: assert property (@(posedge ref_clk) disable iff (rst)
      mode != cell_group_pkg::mode_counter && ctl[`F_CASC_EN] && ctl[`F_CASC_OR]
      && casc_w[i] |-> casc_w[i+1])
      else $error("OR cascade dropped a one");
  end

  // Feedback of the first cell must reach its lookup input c.
  feedback_a: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.ctrl[0][`F_FEEDBACK] |-> c_eff[0] == st_reg.q[0])
    else $error("first cell feedback not routed");

  // The finished chain must leave on the output of this group's parity.
  chain_exit_a: assert property (@(posedge ref_clk) disable iff (rst)
    (GROUP_ODD ? cascade_out_odd : cascade_out_even) == casc_w[CELLS]
    && (GROUP_ODD ? cascade_out_even == cascade_in_even
                  : cascade_out_odd == cascade_in_odd))
    else $error("cascade chain broken between groups");

  // ************************************************************
  // Register slave
  // ************************************************************
  // Merges the enabled byte lanes of a write into the old word.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // Every access answers on its second cycle, which keeps decode simple.
  // A misaligned or unmapped address still gets its one-cycle answer.
  assign bus_req         = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !st_reg.ack;
  assign avs_readdata    = st_reg.rdata;
  assign rel_addr        = 8'(avs_address - `ADDR_CELL_BASE);
  assign cell_idx        = rel_addr[7:`CELL_STRIDE_SH];
  assign in_cells        = (avs_address >= `ADDR_CELL_BASE)
                           && (int'(cell_idx) < CELLS) && (avs_address[1:0] == 2'b00);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_next     = st_reg;
    // The cell registers are rebuilt every cycle; the per cell logic above
    // already folds in the enables, clear and load.
    st_next.q   = cell_d;
    st_next.ack = bus_req && !st_reg.ack;
    // Read data is gathered in the wait cycle and stands in the answer cycle.
    if (avs_read && !st_reg.ack) begin
      st_next.rdata = 32'h0000_0000;
      if (avs_address == `ADDR_STATUS) begin
        st_next.rdata[CELLS-1:0] = st_reg.q;
      end else if (avs_address == `ADDR_CHAIN) begin
        st_next.rdata[1:0] = {carry_w[CELLS], casc_w[CELLS]};
      end else if (in_cells && !rel_addr[2]) begin
        st_next.rdata[15:0] = st_reg.lut[cell_idx];
      end else if (in_cells) begin
        st_next.rdata[`CTRL_W-1:0] = st_reg.ctrl[cell_idx];
      end
    end
    // Writes land in the answer cycle; unmapped writes are dropped.
    // Taking the write in the answer cycle means a master that gives up early
    // leaves the configuration untouched.
    if (avs_write && st_reg.ack && in_cells) begin
      if (!rel_addr[2]) begin
        st_next.lut[cell_idx] = 16'(lane_merge({16'h0000, st_reg.lut[cell_idx]},
                                               avs_writedata, avs_byteenable));
      end else begin
        st_next.ctrl[cell_idx] = `CTRL_W'(lane_merge({21'h00_0000, st_reg.ctrl[cell_idx]},
                                                     avs_writedata, avs_byteenable));
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Reset returns every cell to normal mode with an empty lookup table, so a
  // group left unconfigured drives zeros into its neighbours, apart from the other parity's chain that it passes through.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg.lut   <= {CELLS{`LUT_RST}};
      st_reg.ctrl  <= {CELLS{`CTRL_RST}};
      st_reg.q     <= '0;
      st_reg.ack   <= 1'b0;
      st_reg.rdata <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  // A request is answered after exactly one wait cycle.
  bus_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
    bus_req && !st_reg.ack |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not on second cycle");

  // The answer phase lasts one cycle, so a held request is taken again only after a new wait cycle.
  answer_once_a: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.ack |=> !st_reg.ack)
    else $error("bus answer phase longer than one cycle");

  // A status read returns the registers as they stood when it was taken.
  status_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    avs_read && !st_reg.ack && avs_address == `ADDR_STATUS
    |=> avs_readdata[CELLS-1:0] == $past(st_reg.q))
    else $error("status read does not show the cell registers");

  // An unmapped read must still be answered, and with zero.
  unmapped_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    avs_read && !st_reg.ack && !in_cells && avs_address != `ADDR_STATUS
    && avs_address != `ADDR_CHAIN |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read returned data");
endmodule : cell_group

// ### shared/cell_group_consts.svh
// Offsets, field positions, reset values and counts of the logic cell group.
`ifndef CELL_GROUP_CONSTS_SVH
`define CELL_GROUP_CONSTS_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define ADDR_STATUS    8'h00
`define ADDR_CHAIN     8'h04
`define ADDR_CELL_BASE 8'h40
`define CELL_STRIDE_SH 3
`define CELLS_MAX      16
`define CELLS_DEFAULT  10

// ************************************************************
// Control word fields, one control word per cell
// ************************************************************
`define F_MODE_LO   0
`define F_MODE_HI   1
`define F_CARRY_SEL 2
`define F_CE_SEL    3
`define F_CASC_EN   4
`define F_CASC_OR   5
`define F_PACKED    6
`define F_FEEDBACK  7
`define F_CTL_DATA  8
`define F_CNT_EN    9
`define F_COUNT_UP  10
`define CTRL_W      11

// ************************************************************
// Reset values
// ************************************************************
`define LUT_RST  16'h0000
`define CTRL_RST 11'h000

`endif

// ### shared/cell_group_pkg.sv
// Types shared by the logic cell group files.
package cell_group_pkg;
  // Operating mode of one logic cell; the fourth code acts as normal, but without the packed register.
  typedef enum logic [1:0] {
    mode_normal,
    mode_arith,
    mode_counter
  } cell_mode_e;
endpackage : cell_group_pkg

// ### hw/cascade_link.sv
// Routes the cascade chain between groups of equal parity.
`timescale 1ns/10ps
`include "cell_group_consts.svh"
module cascade_link #(
  parameter bit GROUP_ODD = 1'b0         // Parity of this group in its row.
) (
  input  wire logic chain_last,          // Cascade value leaving the last cell.
  input  wire logic in_even,             // Chain arriving from the previous even group.
  input  wire logic in_odd,              // Chain arriving from the previous odd group.
  output logic      chain_first,         // Cascade value entering the first cell.
  output logic      out_even,            // Chain leaving towards the next even group.
  output logic      out_odd              // Chain leaving towards the next odd group.
);
  // ************************************************************
  // Parity routing
  // ************************************************************
  // The chain of the other parity passes through untouched, so that a long
  // chain skips every alternate group without being broken.
  always_comb begin
    chain_first = GROUP_ODD ? in_odd : in_even;
    out_even    = GROUP_ODD ? in_even : chain_last;
    out_odd     = GROUP_ODD ? chain_last : in_odd;
  end
endmodule : cascade_link

// ### hw/cell_function.sv
// Combinational lookup, carry and cascade logic of one logic cell.
`timescale 1ns/10ps
`include "cell_group_consts.svh"
module cell_function (
  input  wire logic [15:0]          lut_mask,     // Lookup table contents.
  input  wire logic [`CTRL_W-1:0]  ctrl,         // Control word of the cell.
  input  wire logic                 in_a,         // Operand input a.
  input  wire logic                 in_b,         // Operand input b.
  input  wire logic                 in_c,         // Operand input c, after feedback.
  input  wire logic                 in_d,         // Operand input d.
  input  wire logic                 carry_in,     // Carry from the cell below.
  input  wire logic                 cascade_in,   // Cascade from the cell before.
  input  wire logic                 reg_q,        // Present register value.
  output logic                      comb_out,     // Unregistered lookup output.
  output logic                      carry_out,    // Carry towards the next cell.
  output logic                      cascade_out   // Cascade towards the next cell.
);
  cell_group_pkg::cell_mode_e mode;               // Decoded mode.
  logic [3:0]                 idx4;               // Normal mode table index.
  logic [3:0]                 idx_sum;            // Sum half index.
  logic [3:0]                 idx_cry;            // Carry half index.
  logic                       joined;             // Lookup joined with the cascade.

  // ************************************************************
  // Lookup and chains
  // ************************************************************
  // Every cell adds four fresh inputs to the function that the chain builds.
  always_comb begin
    mode    = cell_group_pkg::cell_mode_e'(ctrl[`F_MODE_HI:`F_MODE_LO]);
    idx4    = {in_d, ctrl[`F_CARRY_SEL] ? carry_in : in_c, in_b, in_a};
    idx_sum = {1'b0, carry_in, in_b, in_a};
    idx_cry = {1'b1, carry_in, in_b, in_a};
    comb_out  = lut_mask[idx4];
    carry_out = 1'b0;
    unique case (mode)
      cell_group_pkg::mode_arith: begin
        comb_out  = lut_mask[idx_sum];
        carry_out = lut_mask[idx_cry];
      end
      cell_group_pkg::mode_counter: begin
        // Up counts carry on ones, down counts borrow on zeros.
        carry_out = carry_in & (ctrl[`F_COUNT_UP] ? reg_q : ~reg_q);
      end
      default: begin
        comb_out = lut_mask[idx4];
      end
    endcase
    // An OR chain is the AND chain with inverted inputs and output.
    joined = ctrl[`F_CASC_OR] ? ~(~comb_out & ~cascade_in)
                              : (comb_out & cascade_in);
    if (mode == cell_group_pkg::mode_counter) begin
      cascade_out = cascade_in;
    end else begin
      cascade_out = ctrl[`F_CASC_EN] ? joined : comb_out;
    end
  end
endmodule : cell_function

// ### verif/cell_neighbours.sv
// Model of the neighbouring cells and routing that feed the group chains.
`timescale 1ns/10ps
module cell_neighbours (
  input  wire logic ref_clk,   // Cell clock.
  input  wire logic step,      // Advance the neighbour pattern.
  input  wire logic carry_hi,  // Hold the carry high for counting.
  output logic      carry_in,  // Carry into the group.
  output logic      casc_even, // Even chain into the group.
  output logic      casc_odd   // Odd chain into the group.
);
  logic [7:0] lfsr_reg = 8'h5a; // Neighbour pattern; never reaches zero.
  // Outputs move only when stepped, so they stay steady while a result is checked.
  always @(posedge ref_clk) begin
    if (step) lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5]};
  end
  assign carry_in  = carry_hi | lfsr_reg[2];
  assign casc_even = lfsr_reg[0];
  assign casc_odd  = lfsr_reg[1];
endmodule : cell_neighbours

// ### verif/logic_cell_mode_datapath_test.sv
// Self-checking bench for the logic cell group.
`timescale 1ns/10ps
module logic_cell_mode_datapath_test;
  localparam int C = 10;  // Cells in the group.
  logic         ref_clk = 0, rst = 1, rd = 0, wr = 0, wreq, step = 0, c_hi = 0, pb = 0;
  logic         clr = 0, ld = 0, e0 = 1, e1 = 1, cin, ce, cd, oe, oo, cy;
  logic [7:0]   adr = 8'h00;
  logic [31:0]  wd = 32'h0000_0000, rdat, exp_v, got, q[$];
  logic [C-1:0] a = '0, b = '0, c = '0, d = '0, co, ro, v;
  logic [15:0]  m;   // Lookup mask given to every cell.
  logic [10:0]  ct;  // Control word given to every cell.
  integer       seed = 32'h2e5a;
  int           errors = 0, n_compared = 0;
  always #4 ref_clk = ~ref_clk;
  cell_group #(.CELLS(C), .GROUP_ODD(1'b0)) dut (.ref_clk(ref_clk), .rst(rst),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .operand_in_a(a), .operand_in_b(b), .operand_in_c(c), .operand_in_d(d),
    .carry_in(cin), .carry_out(cy), .sync_clear(clr), .sync_load(ld), .clk_en0(e0),
    .clk_en1(e1), .cascade_in_even(ce), .cascade_in_odd(cd), .cascade_out_even(oe),
    .cascade_out_odd(oo), .comb_out(co), .reg_out(ro));
  cell_neighbours nb (.ref_clk(ref_clk), .step(step), .carry_hi(c_hi), .carry_in(cin),
    .casc_even(ce), .casc_odd(cd));
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // One bus access; the request is held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    int n;
    @(posedge ref_clk);
    rd <= !w; wr <= w; adr <= ad; wd <= dt;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (wreq !== 1'b0 && n < 50);
    rd <= 0; wr <= 0;
    if (n >= 50) begin errors++; final_report(); end
  endtask : bus
  task automatic rdchk(input logic [7:0] ad, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, ad, 32'h0000_0000);
  endtask : rdchk
  task automatic cfg;
    for (int i = 0; i < C; i++) begin
      bus(1'b1, 8'(8'h40 + 8 * i), 32'(m));
      bus(1'b1, 8'(8'h44 + 8 * i), 32'(ct));
    end
  endtask : cfg
  // Reference chain of cells: lookup, carry ripple and cascade join.
  function automatic logic [31:0] ref_out();
    logic s, y; logic [3:0] x; logic [C-1:0] o;
    y = cin; s = ce;
    for (int i = 0; i < C; i++) begin
      x = (ct[1:0] == 2'h1) ? {1'b0, y, b[i], a[i]}
                            : {d[i], ct[2] ? y : (i == 0 && ct[7]) ? d[0] : c[i], b[i], a[i]};
      o[i] = m[x];
      y = (ct[1:0] == 2'h1) ? m[x | 4'h8] : 1'b0;
      s = !ct[4] ? o[i] : ct[5] ? (o[i] | s) : (o[i] & s);
    end
    return 32'({cd, s, y, o});
  endfunction : ref_out
  task automatic rnd_probe;
    logic [31:0] e;
    @(posedge ref_clk);
    a <= C'($random(seed)); b <= C'($random(seed)); c <= C'($random(seed));
    d <= C'($random(seed)); step <= 1;
    @(posedge ref_clk);
    step <= 0;
    @(posedge ref_clk);
    e = ref_out();
    q.push_back(e); pb <= 1;
    @(posedge ref_clk);
    pb <= 0;
    rdchk(8'h00, 32'((ct[6] && ct[1:0] == 2'h0) ? d : e[C-1:0]));
    rdchk(8'h04, 32'({e[C], e[C+1]}));
  endtask : rnd_probe
  // The whole group forms one counter, so no other register shares its controls.
  task automatic count(input int k);
    v = C'($random(seed)) | 1;
    @(posedge ref_clk);
    d <= v; a <= '0; ld <= 1; e0 <= 1;
    @(posedge ref_clk);
    ld <= 0;
    repeat (k) @(posedge ref_clk);
    e0 <= 0;
    rdchk(8'h00, 32'(ct[8] ? v ^ C'((k & 1) << 1) : C'(ct[10] ? v + k : v - k)));
  endtask : count
  // Checker: every bus read or probe pops the oldest expectation.
  always @(posedge ref_clk) begin
    if ((rd && wreq === 1'b0) || pb) begin
      exp_v = q.pop_front();
      got = pb ? 32'({oo, oe, cy, co}) : rdat;
      n_compared++;
      if (got !== exp_v) begin
        errors++;
        $display("CHECK FAILED %0t got %h want %h", $time, got, exp_v);
      end
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    rdchk(8'h44, 32'h0000_0000);
    rdchk(8'h3c, 32'h0000_0000);
    for (int k = 0; k < 10; k++) begin
      m = 16'($random(seed));
      ct = 11'($random(seed)) & 11'h0fd;
      if (ct[2]) ct[6] = 0;
      if (ct[7] && ct[1:0] == 2'h0 && !ct[2]) ct[6] = 1;
      cfg();
      repeat (3) rnd_probe();
    end
    c_hi <= 1;
    m = 16'h0000;
    for (int up = 0; up < 3; up++) begin
      ct = (up == 0) ? 11'h202 : (up == 1) ? 11'h602 : 11'h702;
      cfg();
      count(1 + ($random(seed) & 15));
    end
    @(posedge ref_clk);
    clr <= 1; ld <= 1; e0 <= 1;
    @(posedge ref_clk);
    clr <= 0; ld <= 0; e0 <= 0;
    rdchk(8'h00, 32'h0000_0000);
    final_report();
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    errors++;
    final_report();
  end
endmodule : logic_cell_mode_datapath_test
